/* File: design/dfe_escalate.sv */
// Purpose: Decides serial handling, double fault or shutdown for nested exceptions.
// Assumes: Exception, wake and handler-start inputs are one-cycle pulses on i_ref_clk.
// Notes: Hardware reset is i_rst_b; it is the only way out of the locked state.
// What this block does
// - Every event is sorted into benign, contributory or page-fault class.
// - Contributory then contributory, or page fault then either, makes a double fault.
// - A double fault is delivered on vector 8 as an abort.
// - Every double fault delivery pushes an error code of zero.
// - Saved code selector and instruction pointer are undefined for a double fault.
// - An exception during double fault delivery enters shutdown instead.
// - Shutdown halts execution until NMI, system management interrupt, init or reset.
// - Entering shutdown drives one distinct special bus cycle.
// - Events pending during shutdown are held until after the wake.
// - Shutdown entered inside an NMI handler leaves only by reset.
// - Shutdown entered in system management mode leaves only by reset.
// - Prefetch faults never count as second exceptions; delivery faults do.
// - Vector 9 is never raised by an exception; coprocessor violations become vector 13.
// - A double fault with corrupted delivery state invokes no handler; reset needed.
`timescale 1ns/100ps
`default_nettype none
module dfe_escalate
  import dfe_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_exc_valid,
  input wire logic [7:0] i_exc_vector,
  input wire logic i_exc_is_swint,
  input wire logic i_exc_is_extint,
  input wire logic i_exc_prefetch,
  input wire logic i_exc_coproc_overrun,
  input wire logic i_handler_start,
  input wire logic i_state_corrupt,
  input wire logic i_in_nmi_handler,
  input wire logic i_in_system_management_mode,
  input wire logic i_nmi,
  input wire logic i_system_management_interrupt,
  input wire logic i_init,
  input wire logic i_address_wrap_mask_input,
  output logic o_deliver_valid,
  output logic [7:0] o_deliver_vector,
  output logic o_deliver_abort,
  output logic o_err_push,
  output logic [31:0] o_err_code,
  output logic o_saved_ptr_valid,
  output logic o_shutdown,
  output logic o_shutdown_cycle,
  output logic o_halt_exec,
  output logic o_wake,
  output logic o_locked,
  output logic o_wrap_mask_service
);

  logic [7:0] cls_vector;
  dfe_class_e cls_class;
  dfe_state_e state_q, state_d;
  dfe_class_e class_q, class_d;
  logic reset_only_q, reset_only_d;
  logic pend_q, pend_d;
  logic dv_q, dv_d;
  logic [7:0] vec_q, vec_d;
  logic abort_q, abort_d;
  logic err_push_q, err_push_d;
  logic [31:0] err_q, err_d;
  logic ptr_q, ptr_d;
  logic shut_cyc_q, shut_cyc_d;
  logic wake_q, wake_d;
  logic svc_q, svc_d;
  logic shut_q, shut_d;
  logic halt_q, halt_d;
  logic lock_q, lock_d;
  logic exc_second;
  logic any_wake;

  dfe_classify u_classify (
    .i_vector(i_exc_vector),
    .i_is_swint(i_exc_is_swint),
    .i_is_extint(i_exc_is_extint),
    .i_coproc_overrun(i_exc_coproc_overrun),
    .o_vector(cls_vector),
    .o_class(cls_class)
  );

  // Prefetch faults are dropped as second events; faults while entering a handler still count.
  assign exc_second = i_exc_valid && !i_exc_prefetch;
  assign any_wake = i_nmi || i_system_management_interrupt || i_init;

  // Escalation sequencing. A new exception beats a handler start in the same cycle,
  // because a fault during control transfer belongs to the delivery still in flight.
  always_comb begin
    state_d = state_q;
    class_d = class_q;
    reset_only_d = reset_only_q;
    dv_d = 1'b0;
    vec_d = vec_q;
    abort_d = 1'b0;
    err_push_d = 1'b0;
    err_d = err_q;
    ptr_d = ptr_q;
    shut_cyc_d = 1'b0;
    wake_d = 1'b0;
    case (state_q)
      DFE_ST_IDLE: begin
        if (i_exc_valid) begin
          state_d = DFE_ST_DELIVER;
          class_d = cls_class;
          dv_d = 1'b1;
          vec_d = cls_vector;
          ptr_d = 1'b1;
        end
      end
      DFE_ST_DELIVER: begin
        if (exc_second && dfe_is_double(class_q, cls_class)) begin
          if (i_state_corrupt) begin
            state_d = DFE_ST_LOCKED;
          end else begin
            state_d = DFE_ST_DBL;
            dv_d = 1'b1;
            vec_d = DFE_VEC_DBL;
            abort_d = 1'b1;
            err_push_d = 1'b1;
            err_d = DFE_ERR_DBL;
            ptr_d = 1'b0;
          end
        end else if (exc_second) begin
          class_d = cls_class;
          dv_d = 1'b1;
          vec_d = cls_vector;
          ptr_d = 1'b1;
        end else if (i_handler_start) begin
          state_d = DFE_ST_IDLE;
          class_d = DFE_BENIGN;
        end
      end
      DFE_ST_DBL: begin
        if (exc_second) begin
          state_d = DFE_ST_SHUT;
          shut_cyc_d = 1'b1;
          reset_only_d = i_in_nmi_handler || i_in_system_management_mode;
        end else if (i_handler_start) begin
          state_d = DFE_ST_IDLE;
          class_d = DFE_BENIGN;
        end
      end
      DFE_ST_SHUT: begin
        if (any_wake && !reset_only_q) begin
          state_d = DFE_ST_IDLE;
          class_d = DFE_BENIGN;
          wake_d = 1'b1;
        end
      end
      DFE_ST_LOCKED: begin
        state_d = DFE_ST_LOCKED;
      end
      default: begin
        state_d = DFE_ST_IDLE;
      end
    endcase
    // Status levels are registered copies of the next state, so the pins come straight off flops.
    shut_d = (state_d == DFE_ST_SHUT);
    halt_d = (state_d == DFE_ST_SHUT) || (state_d == DFE_ST_LOCKED);
    lock_d = (state_d == DFE_ST_LOCKED);
  end

  // Held wake-independent events: caught while shut down, serviced once running again.
  always_comb begin
    svc_d = (state_q != DFE_ST_SHUT) && (state_q != DFE_ST_LOCKED) &&
            (pend_q || i_address_wrap_mask_input);
    pend_d = ((state_q == DFE_ST_SHUT) && i_address_wrap_mask_input) ||
             (pend_q && !svc_d);
  end

  // Registers for state and every output.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      state_q <= DFE_ST_IDLE;
      class_q <= DFE_BENIGN;
      reset_only_q <= 1'b0;
      pend_q <= 1'b0;
      dv_q <= 1'b0;
      vec_q <= 8'h00;
      abort_q <= 1'b0;
      err_push_q <= 1'b0;
      err_q <= 32'h0000_0000;
      ptr_q <= 1'b0;
      shut_cyc_q <= 1'b0;
      wake_q <= 1'b0;
      svc_q <= 1'b0;
      shut_q <= 1'b0;
      halt_q <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      state_q <= state_d;
      class_q <= class_d;
      reset_only_q <= reset_only_d;
      pend_q <= pend_d;
      dv_q <= dv_d;
      vec_q <= vec_d;
      abort_q <= abort_d;
      err_push_q <= err_push_d;
      err_q <= err_d;
      ptr_q <= ptr_d;
      shut_cyc_q <= shut_cyc_d;
      wake_q <= wake_d;
      svc_q <= svc_d;
      shut_q <= shut_d;
      halt_q <= halt_d;
      lock_q <= lock_d;
    end
  end

  assign o_deliver_valid = dv_q;
  assign o_deliver_vector = vec_q;
  assign o_deliver_abort = abort_q;
  assign o_err_push = err_push_q;
  assign o_err_code = err_q;
  assign o_saved_ptr_valid = ptr_q;
  assign o_shutdown = shut_q;
  assign o_shutdown_cycle = shut_cyc_q;
  assign o_halt_exec = halt_q;
  assign o_wake = wake_q;
  assign o_locked = lock_q;
  assign o_wrap_mask_service = svc_q;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  a_dbl_vector_code: assert property (o_deliver_abort |->
    (o_deliver_valid && o_deliver_vector == DFE_VEC_DBL && o_err_push && o_err_code == 32'h0))
    else $error("double fault not on vector 8 with zero code");
  a_dbl_ptr_undef: assert property (o_deliver_abort |-> !o_saved_ptr_valid)
    else $error("saved pointer marked valid on double fault");
  a_contrib_pair: assert property ((state_q == DFE_ST_DELIVER && exc_second &&
    class_q == DFE_CONTRIB && cls_class == DFE_CONTRIB && !i_state_corrupt) |=> o_deliver_abort)
    else $error("contributory pair did not escalate");
  a_benign_serial: assert property ((state_q == DFE_ST_DELIVER && exc_second &&
    cls_class == DFE_BENIGN) |=> (o_deliver_valid && !o_deliver_abort))
    else $error("benign second event not handled serially");
  a_shut_entry: assert property ((state_q == DFE_ST_DBL && exc_second) |=>
    (o_shutdown && o_shutdown_cycle ##1 !o_shutdown_cycle))
    else $error("shutdown entry or bus cycle wrong");
  a_shut_halts: assert property (o_shutdown |-> (o_halt_exec && !o_deliver_valid))
    else $error("execution not halted in shutdown");
  a_shut_wake: assert property ((o_shutdown && !reset_only_q && i_nmi) |=>
    (!o_shutdown && o_wake))
    else $error("wake from shutdown not taken");
  a_reset_only: assert property ((o_shutdown && reset_only_q) |=> o_shutdown)
    else $error("left reset-only shutdown without reset");
  a_pend_hold: assert property ((o_shutdown && i_address_wrap_mask_input &&
    !any_wake) |=> (pend_q && !o_wrap_mask_service))
    else $error("pending event lost or serviced in shutdown");
  a_no_vec9: assert property (o_deliver_valid |-> o_deliver_vector != DFE_VEC_CSO)
    else $error("vector 9 raised");
  a_prefetch_skip: assert property ((state_q == DFE_ST_DELIVER && i_exc_valid &&
    i_exc_prefetch && !i_handler_start) |=> (!o_deliver_valid && state_q == DFE_ST_DELIVER))
    else $error("prefetch fault counted as second event");
  a_corrupt_lock: assert property ((state_q == DFE_ST_DELIVER && exc_second &&
    dfe_is_double(class_q, cls_class) && i_state_corrupt) |=>
    (o_locked && !o_deliver_valid) [*2])
    else $error("handler invoked with corrupted state");

endmodule
`default_nettype wire

/* File: design/dfe_pkg.sv */
// Purpose: Shared constants and types for the double fault escalation unit.
// Assumes: Vectors are eight bits wide, as the core presents them.
// Notes: The class encoding is internal and never leaves the core.
package dfe_pkg;

  typedef enum logic [1:0] {
    DFE_BENIGN = 2'b00,
    DFE_CONTRIB = 2'b01,
    DFE_PAGE = 2'b10
  } dfe_class_e;

  typedef enum logic [2:0] {
    DFE_ST_IDLE = 3'b000,
    DFE_ST_DELIVER = 3'b001,
    DFE_ST_DBL = 3'b010,
    DFE_ST_SHUT = 3'b011,
    DFE_ST_LOCKED = 3'b100
  } dfe_state_e;

  localparam int DFE_VEC_W = 8;
  localparam int DFE_ERR_W = 32;
  localparam logic [7:0] DFE_VEC_DIVIDE = 8'h00;
  localparam logic [7:0] DFE_VEC_DBL = 8'h08;
  localparam logic [7:0] DFE_VEC_CSO = 8'h09;
  localparam logic [7:0] DFE_VEC_TS = 8'h0A;
  localparam logic [7:0] DFE_VEC_PROT = 8'h0D;
  localparam logic [7:0] DFE_VEC_PF = 8'h0E;
  localparam logic [31:0] DFE_ERR_DBL = 32'h0000_0000;

  // Pairing decision between the class in delivery and a newly detected class.
  function automatic logic dfe_is_double(input dfe_class_e first, input dfe_class_e second);
    logic second_bad;
    second_bad = (second == DFE_CONTRIB) || (second == DFE_PAGE);
    dfe_is_double = ((first == DFE_CONTRIB) && (second == DFE_CONTRIB)) ||
                    ((first == DFE_PAGE) && second_bad);
  endfunction

endpackage

/* File: design/dfe_classify.sv */
// Purpose: Sorts one detected event into its escalation class and final vector.
// Assumes: Inputs are stable while the event is offered.
// Notes: Purely combinational; the parent registers everything it drives out.
`timescale 1ns/100ps
`default_nettype none
module dfe_classify
  import dfe_pkg::*;
(
  input wire logic [7:0] i_vector,
  input wire logic i_is_swint,
  input wire logic i_is_extint,
  input wire logic i_coproc_overrun,
  output logic [7:0] o_vector,
  output dfe_class_e o_class
);

  // Interrupts are benign whatever their vector; the retired vector folds into protection.
  always_comb begin
    o_vector = i_vector;
    o_class = DFE_BENIGN;
    if (i_is_swint || i_is_extint) begin
      o_class = DFE_BENIGN;
    end else if (i_coproc_overrun || (i_vector == DFE_VEC_CSO)) begin
      o_vector = DFE_VEC_PROT;
      o_class = DFE_CONTRIB;
    end else if ((i_vector == DFE_VEC_DIVIDE) ||
                 ((i_vector >= DFE_VEC_TS) && (i_vector <= DFE_VEC_PROT))) begin
      o_class = DFE_CONTRIB;
    end else if (i_vector == DFE_VEC_PF) begin
      o_class = DFE_PAGE;
    end else begin
      o_class = DFE_BENIGN;
    end
  end

endmodule
`default_nettype wire

/* File: testbench/dfe_sys_model.sv */
// Purpose: Stands in for the system logic that watches for the shutdown bus cycle.
// Assumes: The shutdown cycle is a one-cycle pulse on i_ref_clk.
// Notes: Selector 3 matches no wake line, so no wake line is raised.
`timescale 1ns/100ps
`default_nettype none
module dfe_sys_model #(
  parameter int DELAY = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_shutdown_cycle,
  input wire logic [1:0] i_wake_sel,
  output logic o_nmi,
  output logic o_system_management_interrupt,
  output logic o_init
);
  int cnt;

  // Wake lines are quiet from time zero, before the first edge.
  initial begin
    o_nmi = 1'b0;
    o_system_management_interrupt = 1'b0;
    o_init = 1'b0;
    cnt = 0;
  end

  // After the shutdown cycle wait DELAY cycles, then pulse one chosen wake line.
  always @(posedge i_ref_clk) begin
    o_nmi <= 1'b0;
    o_system_management_interrupt <= 1'b0;
    o_init <= 1'b0;
    if (!i_rst_b) begin
      cnt <= 0;
    end else if (i_shutdown_cycle) begin
      cnt <= DELAY;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        o_nmi <= (i_wake_sel == 2'h0);
        o_system_management_interrupt <= (i_wake_sel == 2'h1);
        o_init <= (i_wake_sel == 2'h2);
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/double_fault_escalation_tb.sv */
// Purpose: Self-checking bench for the double fault escalation unit.
// Assumes: Exceptions are one-cycle pulses taken at the rising edge.
// Notes: System logic that answers shutdown is the separate model.
`timescale 1ns/100ps
`default_nettype none
module double_fault_escalation_tb;
  import dfe_pkg::*;
  logic i_ref_clk, i_rst_b, i_exc_valid, i_exc_is_swint, i_exc_is_extint, i_exc_prefetch;
  logic i_exc_coproc_overrun, i_handler_start, i_state_corrupt, i_in_nmi_handler;
  logic i_in_system_management_mode, i_system_management_interrupt;
  logic i_nmi, i_init, i_address_wrap_mask_input, o_deliver_valid, o_deliver_abort;
  logic o_err_push, o_saved_ptr_valid, o_shutdown, o_shutdown_cycle, o_halt_exec, o_wake;
  logic o_locked, o_wrap_mask_service;
  logic [7:0] i_exc_vector, o_deliver_vector;
  logic [31:0] o_err_code;
  logic [1:0] wake_sel;
  int fail_count, checked;

  dfe_escalate i_dfe_escalate (.i_ref_clk, .i_rst_b, .i_exc_valid, .i_exc_vector,
    .i_exc_is_swint, .i_exc_is_extint, .i_exc_prefetch, .i_exc_coproc_overrun,
    .i_handler_start, .i_state_corrupt, .i_in_nmi_handler, .i_in_system_management_mode,
    .i_nmi, .i_system_management_interrupt,
    .i_init, .i_address_wrap_mask_input, .o_deliver_valid, .o_deliver_vector,
    .o_deliver_abort, .o_err_push, .o_err_code, .o_saved_ptr_valid, .o_shutdown,
    .o_shutdown_cycle, .o_halt_exec, .o_wake, .o_locked, .o_wrap_mask_service);

  dfe_sys_model #(.DELAY(8)) i_dfe_sys_model (.i_ref_clk, .i_rst_b,
    .i_shutdown_cycle(o_shutdown_cycle), .i_wake_sel(wake_sel), .o_nmi(i_nmi),
    .o_system_management_interrupt(i_system_management_interrupt), .o_init(i_init));

  // Free-running 10 MHz clock.
  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Reset is held four edges; it also drops the mode levels so each scenario starts clean.
  task automatic do_reset();
    @(posedge i_ref_clk);
    i_rst_b <= 1'b0;
    i_in_nmi_handler <= 1'b0;
    i_in_system_management_mode <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    #1;
    chk("reset outputs", 0, {o_deliver_valid, o_deliver_vector, o_deliver_abort, o_err_push,
      o_saved_ptr_valid, o_shutdown, o_shutdown_cycle, o_halt_exec, o_wake, o_locked,
      o_wrap_mask_service});
  endtask

  // Flag bits are prefetch, coprocessor overrun, external and software interrupt.
  task automatic exc(input logic [7:0] v, input logic [3:0] f);
    @(posedge i_ref_clk);
    i_exc_valid <= 1'b1;
    i_exc_vector <= v;
    {i_exc_prefetch, i_exc_coproc_overrun, i_exc_is_extint, i_exc_is_swint} <= f;
    @(posedge i_ref_clk);
    i_exc_valid <= 1'b0;
    {i_exc_prefetch, i_exc_coproc_overrun, i_exc_is_extint, i_exc_is_swint} <= 4'h0;
    #1;
  endtask

  task automatic hstart();
    @(posedge i_ref_clk);
    i_handler_start <= 1'b1;
    @(posedge i_ref_clk);
    i_handler_start <= 1'b0;
  endtask

  // Expected class, worked out independently of the design's own helpers.
  function automatic dfe_class_e cls(input logic [7:0] v, input logic [3:0] f);
    if (f[2]) return DFE_CONTRIB;
    if (f[1] || f[0]) return DFE_BENIGN;
    if (v == 8'h00 || v == 8'h09 || (v >= 8'h0A && v <= 8'h0D)) return DFE_CONTRIB;
    if (v == 8'h0E) return DFE_PAGE;
    return DFE_BENIGN;
  endfunction

  // Every first class against a table of second events, qualifiers included.
  task automatic t_pairs();
    logic [7:0] fv[3] = '{8'h03, 8'h0C, 8'h0E};
    logic [7:0] sv[11] = '{8'h01, 8'h07, 8'h09, 8'h0A, 8'h0D, 8'h0E, 8'h0F, 8'h12, 8'h0D, 8'h05,
                           8'h0E};
    logic [3:0] sf[11] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h4, 4'h2};
    dfe_class_e c1;
    dfe_class_e c2;
    logic dbl;
    logic [7:0] ev;
    foreach (fv[i]) begin
      foreach (sv[j]) begin
        c1 = cls(fv[i], 4'h0);
        c2 = cls(sv[j], sf[j]);
        dbl = (c1 == DFE_CONTRIB && c2 == DFE_CONTRIB) || (c1 == DFE_PAGE && c2 != DFE_BENIGN);
        ev = (sf[j][2] || (sv[j] == 8'h09 && sf[j] == 4'h0)) ? 8'h0D : sv[j];
        exc(fv[i], 4'h0);
        chk("first vector", fv[i], o_deliver_vector);
        exc(sv[j], sf[j]);
        chk("second valid", 1, o_deliver_valid);
        chk("abort", dbl, o_deliver_abort);
        chk("vector", dbl ? 8'h08 : ev, o_deliver_vector);
        chk("err push", dbl, o_err_push);
        chk("saved ptr", !dbl, o_saved_ptr_valid);
        if (dbl) chk("err code", 0, o_err_code);
        hstart();
      end
    end
  endtask

  // Prefetch faults do not pair; a finished handler clears the held class.
  task automatic t_prefetch();
    exc(8'h00, 4'h0);
    exc(8'h0D, 4'h8);
    chk("prefetch refused", 0, o_deliver_valid);
    exc(8'h0D, 4'h0);
    chk("delivery fault", 1, o_deliver_abort);
    hstart();
    exc(8'h00, 4'h0);
    hstart();
    exc(8'h00, 4'h0);
    chk("class cleared", 0, o_deliver_abort);
    hstart();
  endtask

  // Escalate to shutdown, offer a pending event, then watch for wake or lasting halt.
  task automatic t_shut(input logic [1:0] sel, input logic nmih, input logic mgmt);
    int wk;
    int svc_in;
    int svc_out;
    logic stay;
    stay = nmih || mgmt || sel == 2'h3;
    wk = 0;
    svc_in = 0;
    svc_out = 0;
    @(posedge i_ref_clk);
    wake_sel <= sel;
    i_in_nmi_handler <= nmih;
    i_in_system_management_mode <= mgmt;
    exc(8'h00, 4'h0);
    exc(8'h0B, 4'h0);
    exc(8'h0E, 4'h0);
    chk("shutdown", 1, o_shutdown);
    chk("bus cycle", 1, o_shutdown_cycle);
    chk("halt", 1, o_halt_exec);
    @(posedge i_ref_clk);
    i_address_wrap_mask_input <= 1'b1;
    #1;
    chk("bus cycle end", 0, o_shutdown_cycle);
    @(posedge i_ref_clk);
    i_address_wrap_mask_input <= 1'b0;
    exc(8'h0D, 4'h0);
    chk("exc in shutdown", 0, o_deliver_valid);
    repeat (30) begin
      @(posedge i_ref_clk);
      #1;
      if (o_wake === 1'b1) wk++;
      if (o_wrap_mask_service === 1'b1 && o_shutdown === 1'b1) svc_in++;
      if (o_wrap_mask_service === 1'b1 && o_shutdown === 1'b0) svc_out++;
    end
    chk("wake count", !stay, wk);
    chk("still shut", stay, o_shutdown);
    chk("held service", 0, svc_in);
    chk("later service", !stay, svc_out);
    do_reset();
  endtask

  // Corrupted delivery state locks the core until reset.
  task automatic t_corrupt();
    exc(8'h00, 4'h0);
    @(posedge i_ref_clk);
    i_state_corrupt <= 1'b1;
    exc(8'h0C, 4'h0);
    chk("locked", 1, o_locked);
    chk("no handler", 0, o_deliver_valid);
    @(posedge i_ref_clk);
    i_state_corrupt <= 1'b0;
    exc(8'h0D, 4'h0);
    chk("still locked", 3, {o_locked, o_halt_exec});
    do_reset();
  endtask

  // Main sequence; every input has a value at time zero.
  initial begin
    {i_rst_b, i_exc_valid, i_exc_is_swint, i_exc_is_extint, i_exc_prefetch, i_exc_coproc_overrun,
     i_handler_start, i_state_corrupt, i_in_nmi_handler, i_in_system_management_mode,
     i_address_wrap_mask_input} = '0;
    i_exc_vector = 8'h00;
    wake_sel = 2'h0;
    do_reset();
    t_pairs();
    t_prefetch();
    for (int s = 0; s < 4; s++) begin
      t_shut(2'(s), 1'b0, 1'b0);
    end
    t_shut(2'h0, 1'b1, 1'b0);
    t_shut(2'h1, 1'b0, 1'b1);
    t_corrupt();
    final_report();
  end

  // The run needs about 500 cycles; a hang is cut short well beyond that.
  initial begin
    repeat (6000) @(posedge i_ref_clk);
    fail_count++;
    final_report();
  end
endmodule
`default_nettype wire
